//--- common/ipc_channel_if.sv
`timescale 1ns/1ps
`default_nettype none
// Shared event channels: each end offers pulses, the wire is their OR
interface ipc_channel_if #(
    parameter int NUM_CHANNELS = 16
);
    logic [NUM_CHANNELS-1:0] dev_pulse;
    logic [NUM_CHANNELS-1:0] peer_pulse;
    logic [NUM_CHANNELS-1:0] chan_line;
    // Wired-OR combine, several drivers in one cycle never conflict
    assign chan_line = dev_pulse | peer_pulse;
    modport device_end (output dev_pulse, input chan_line);
    modport peer_end (output peer_pulse, input chan_line);
endinterface
`default_nettype wire

//--- common/ipc_sig_pkg.sv
package ipc_sig_pkg;
    // Default geometry of one signalling instance
    localparam int NUM_CHANNELS = 16;
    localparam int NUM_SEND = 8;
    localparam int NUM_RECV = 8;
    localparam int NUM_GP_WORDS = 4;
    localparam int DATA_W = 32;
    localparam int XCONN_CHANNELS = 16;
    localparam int XCONN_IDX_W = 4;
    // Register word indices (byte address = 4 * index)
    localparam logic [8:0] IDX_SEND_TRIG = 9'h000;
    localparam logic [8:0] IDX_SEND_SUB = 9'h020;
    localparam logic [8:0] IDX_RECV_FLAG = 9'h040;
    localparam logic [8:0] IDX_RECV_PUB = 9'h060;
    localparam logic [8:0] IDX_INT_EN = 9'h0c0;
    localparam logic [8:0] IDX_SEND_MASK = 9'h144;
    localparam logic [8:0] IDX_RECV_MASK = 9'h164;
    localparam logic [8:0] IDX_GP_STORE = 9'h184;
    // Subscription and publish field positions
    localparam int SUB_EN_BIT = 31;
    localparam int SUB_IDX_LSB = 0;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Minimum spacing of events on one channel, in ns, and in cycles at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_SPACING_NS = 200;
    localparam int MIN_SPACING_CYC =
        (MIN_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- sim/ipc_chan_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the shared channel lines between the two ends
module ipc_chan_assertions #(
    parameter int N_CH = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Channel signals
    input wire logic [N_CH-1:0] dev_pulse_i,
    input wire logic [N_CH-1:0] peer_pulse_i,
    input wire logic [N_CH-1:0] chan_line_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // A pulse from either end; a peer pulse is followed by a quiet peer cycle
    sequence dev_fire;
        |dev_pulse_i;
    endsequence
    sequence peer_fire;
        |peer_pulse_i;
    endsequence
    sequence peer_quiet;
        peer_pulse_i == '0;
    endsequence
    wired_or_a: assert property (chan_line_i == (dev_pulse_i | peer_pulse_i))
        else $error("channel line is not the OR of both ends");
    dev_reach_a: assert property
        (dev_fire |-> (chan_line_i & dev_pulse_i) == dev_pulse_i)
        else $error("device pulse missing on channel line");
    peer_reach_a: assert property
        (peer_fire |-> (chan_line_i & peer_pulse_i) == peer_pulse_i)
        else $error("peer pulse missing on channel line");
    peer_space_a: assert property (peer_fire |=> peer_quiet)
        else $error("peer pulses closer than spacing");
    dev_rst_a: assert property (disable iff (1'b0) sys_rst_i |=> dev_pulse_i == '0)
        else $error("device pulses during reset");
    peer_rst_a: assert property (disable iff (1'b0) sys_rst_i |=> peer_quiet)
        else $error("peer pulses during reset");
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ipc_sig_pkg::*;
    logic clk_sys_i = 0, sys_rst_i = 1, wr = 0, rd = 0, req = 0, irq, rdy;
    logic [8:0] idx = 9'h000;
    logic [31:0] wd = 32'h0, rdat;
    logic [15:0] xin = 16'h0, chans = 16'h0, xpub, seen, acc_s, acc_p;
    int n_fail = 0;
    int check_count = 0;
    ipc_channel_if #(.NUM_CHANNELS(16)) chan_if ();
    ipc_sig_device ipc_sig_device_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_idx_i(idx), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .xconn_evt_i(xin), .xconn_pub_o(xpub), .irq_o(irq),
        .chan(chan_if.device_end));
    ipc_sig_peer ipc_sig_peer_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .send_req_i(req), .send_chans_i(chans), .send_ready_o(rdy), .seen_o(seen),
        .chan(chan_if.peer_end));
    ipc_chan_assertions ipc_chan_assertions_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .dev_pulse_i(chan_if.dev_pulse),
        .peer_pulse_i(chan_if.peer_pulse), .chan_line_i(chan_if.chan_line));
    // Clock, 100 ns period
    always #50 clk_sys_i = ~clk_sys_i;
    task automatic give_verdict(bit hung);
        if (hung) begin
            n_fail++;
        end
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Register port cycles, one strobe cycle each
    task automatic wr_reg(logic [8:0] i, logic [31:0] d);
        @(negedge clk_sys_i) {wr, idx, wd} = {1'b1, i, d};
        @(negedge clk_sys_i) wr = 0;
    endtask
    task automatic rd_reg(logic [8:0] i, logic [31:0] e, string nm);
        @(negedge clk_sys_i) {rd, idx} = {1'b1, i};
        @(negedge clk_sys_i) rd = 0;
        chk(nm, e, rdat);
    endtask
    // Peer request, waits for ready under a bound
    task automatic peer_send(logic [15:0] c);
        int k = 0;
        while (rdy !== 1'b1 && k < 20) begin
            @(negedge clk_sys_i);
            k++;
        end
        if (rdy !== 1'b1) begin
            $display("MISMATCH peer ready wait exp 1 got %b", rdy);
            give_verdict(1);
        end
        @(negedge clk_sys_i) {req, chans} = {1'b1, c};
        @(negedge clk_sys_i) req = 0;
        chk("peer busy", 32'h0, {31'h0, rdy});
    endtask
    // Collects channel activity and publish pulses over a few cycles
    task automatic watch();
        {acc_s, acc_p} = '0;
        repeat (6) begin
            @(posedge clk_sys_i);
            #1;
            {acc_s, acc_p} = {acc_s | seen, acc_p | xpub};
        end
    endtask
    initial begin
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 0;
        // Reset state, storage words, unmapped place
        rd_reg(IDX_RECV_FLAG, 32'h0, "flag0 reset");
        chk("irq reset", 32'h0, {31'h0, irq});
        for (int g = 0; g < NUM_GP_WORDS; g++) begin
            wr_reg(IDX_GP_STORE + 9'(g), 32'ha5a5_0000 + 32'(g));
        end
        for (int g = 0; g < NUM_GP_WORDS; g++) begin
            rd_reg(IDX_GP_STORE + 9'(g), 32'ha5a5_0000 + 32'(g), "gp");
        end
        rd_reg(IDX_RECV_FLAG, 32'h0, "flag0 after gp");
        rd_reg(9'h1ff, 32'h0, "unmapped");
        $display("test regs done");
        // Every send task on its own pair of channels
        for (int n = 0; n < NUM_SEND; n++) begin
            wr_reg(IDX_SEND_MASK + 9'(n), 32'h3 << (2 * n));
            wr_reg(IDX_SEND_TRIG + 9'(n), 32'h1);
            watch();
            chk("send chans", 32'h3 << (2 * n), {16'h0, acc_s});
        end
        rd_reg(IDX_SEND_MASK, 32'h3, "send mask0");
        rd_reg(IDX_RECV_FLAG + 9'h004, 32'h0, "flag4 idle");
        // Interconnect subscription, disabled then enabled
        for (int en = 0; en < 2; en++) begin
            wr_reg(IDX_SEND_SUB + 9'h001, {en[0], 31'h5});
            @(negedge clk_sys_i) xin = 16'h0020;
            @(negedge clk_sys_i) xin = 16'h0;
            watch();
            chk("sub send", en == 1 ? 32'hc : 32'h0, {16'h0, acc_s});
        end
        $display("test send done");
        // Receive events, interrupt on event 0, publish on index 7, ack on channel 15
        wr_reg(IDX_INT_EN, 32'h1);
        wr_reg(IDX_RECV_PUB, 32'h8000_0007);
        wr_reg(IDX_SEND_MASK + 9'h007, 32'h8000);
        for (int j = 0; j < 4; j++) begin
            wr_reg(IDX_RECV_MASK + 9'(j), 32'h11 << j);
            peer_send(16'h10 << j);
            watch();
            chk("peer chan", 32'h10 << j, {16'h0, acc_s});
            rd_reg(IDX_RECV_FLAG + 9'(j), 32'h1, "recv flag");
            chk("irq", j == 0 ? 32'h1 : 32'h0, {31'h0, irq});
            chk("publish", j == 0 ? 32'h80 : 32'h0, {16'h0, acc_p});
            wr_reg(IDX_SEND_TRIG + 9'h007, 32'h1);
            watch();
            chk("ack chan", 32'h8000, {16'h0, acc_s});
            wr_reg(IDX_RECV_FLAG + 9'(j), 32'h0);
            rd_reg(IDX_RECV_FLAG + 9'(j), 32'h0, "flag clear");
        end
        $display("test recv done");
        give_verdict(0);
    end
endmodule
`default_nettype wire

//--- verilog/ipc_sig_device.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) One block per processor, exchanges channel events
// (R2) Several independent send tasks and receive events
// (R3) Send task pulses all channels in mask
// (R4) Receive event raised by any masked channel
// (R5) Every mask may select any channel
// (R6) Concurrent pulses on a channel combine cleanly
// (R7) Close pulses on one channel may merge
// (R8) Software keeps same-channel events spaced apart
// (R9) Software may dedicate a channel to acknowledgements
// (R10) Channel events carry no data payload
// (R11) Channel meaning is software defined only
// (R12) General storage words, free, no side effects
// (R13) Storage uses same register access path
// (R14) Tasks and events reachable over event interconnect
// (R15) Peripheral events relay without processor code
// (R16) Writing one to trigger fires send task
// (R17) Receive flag reads one after event
// (R18) Send subscription: channel index plus enable
// (R19) Counts and spacing are design parameters
// (R20) Flag sticky until zero written; gated interrupt
module ipc_sig_device
    import ipc_sig_pkg::*;
#(
    parameter int N_CH = NUM_CHANNELS, // [R19]
    parameter int N_SEND = NUM_SEND,
    parameter int N_RECV = NUM_RECV,
    parameter int N_XC = XCONN_CHANNELS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Local register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [8:0] reg_idx_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Local event interconnect
    input wire logic [N_XC-1:0] xconn_evt_i,
    output logic [N_XC-1:0] xconn_pub_o,
    // Interrupt
    output logic irq_o,
    // Shared channels
    ipc_channel_if.device_end chan
);
    logic [N_SEND-1:0][N_CH-1:0] send_mask_reg;
    logic [N_RECV-1:0][N_CH-1:0] recv_mask_reg;
    logic [N_SEND-1:0][31:0] send_sub_reg;
    logic [N_RECV-1:0][31:0] recv_pub_reg;
    logic [NUM_GP_WORDS-1:0][31:0] gp_store_reg;
    logic [N_RECV-1:0] recv_flag_reg;
    logic [N_RECV-1:0] int_en_reg;
    logic [N_SEND-1:0] fire;
    logic [N_RECV-1:0] hit;
    logic [N_CH-1:0] pulse_next;
    logic [N_CH-1:0] pulse_reg;
    logic [N_CH-1:0] line_q;
    logic [N_XC-1:0] pub_next;

    // Send task fire: register write of one or subscribed interconnect event
    always_comb begin
        for (int i = 0; i < N_SEND; i++) begin
            fire[i] = (reg_wr_i && reg_idx_i == IDX_SEND_TRIG + 9'(i)
                       && reg_wdata_i[0]) // [R16] [R2]
                      || (send_sub_reg[i][SUB_EN_BIT]
                          && xconn_evt_i[send_sub_reg[i][XCONN_IDX_W-1:0]]); // [R18] [R14] [R15]
        end
    end

    // Broadcast: OR of masks of all fired tasks, no channel reserved
    always_comb begin
        pulse_next = '0;
        for (int i = 0; i < N_SEND; i++) begin
            if (fire[i]) begin
                pulse_next = pulse_next | send_mask_reg[i]; // [R3] [R5]
            end
        end
    end

    // Channel pulses last one cycle, no data rides with them
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pulse_reg <= '0;
        end else begin
            pulse_reg <= pulse_next; // [R10] [R1]
        end
    end
    assign chan.dev_pulse = pulse_reg; // [R6]

    // Channel lines come from logic on this clock; a one-cycle sample
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            line_q <= '0;
        end else begin
            line_q <= chan.chan_line;
        end
    end

    // Receive match: any masked channel firing raises the event
    always_comb begin
        for (int j = 0; j < N_RECV; j++) begin
            hit[j] = |(line_q & recv_mask_reg[j]); // [R4] [R5] [R7]
        end
    end

    // Sticky flags, set wins over software clear
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            recv_flag_reg <= '0;
        end else begin
            for (int j = 0; j < N_RECV; j++) begin
                if (hit[j]) begin
                    recv_flag_reg[j] <= 1'b1; // [R17]
                end else if (reg_wr_i && reg_idx_i == IDX_RECV_FLAG + 9'(j)
                             && !reg_wdata_i[0]) begin
                    recv_flag_reg[j] <= 1'b0; // [R20]
                end
            end
        end
    end

    // Publish receive events onto the interconnect as one-cycle pulses
    always_comb begin
        pub_next = '0;
        for (int j = 0; j < N_RECV; j++) begin
            if (hit[j] && recv_pub_reg[j][SUB_EN_BIT]) begin
                pub_next[recv_pub_reg[j][XCONN_IDX_W-1:0]] = 1'b1; // [R14] [R15]
            end
        end
    end

    // Registered publish pulses toward the interconnect
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            xconn_pub_o <= '0;
        end else begin
            xconn_pub_o <= pub_next;
        end
    end

    // Configuration and storage registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            send_mask_reg <= '0;
            recv_mask_reg <= '0;
            send_sub_reg <= '0;
            recv_pub_reg <= '0;
            gp_store_reg <= '0;
            int_en_reg <= '0;
        end else if (reg_wr_i) begin
            for (int i = 0; i < N_SEND; i++) begin
                if (reg_idx_i == IDX_SEND_MASK + 9'(i)) begin
                    send_mask_reg[i] <= reg_wdata_i[N_CH-1:0];
                end
                if (reg_idx_i == IDX_SEND_SUB + 9'(i)) begin
                    send_sub_reg[i] <= reg_wdata_i; // [R18]
                end
            end
            for (int j = 0; j < N_RECV; j++) begin
                if (reg_idx_i == IDX_RECV_MASK + 9'(j)) begin
                    recv_mask_reg[j] <= reg_wdata_i[N_CH-1:0];
                end
                if (reg_idx_i == IDX_RECV_PUB + 9'(j)) begin
                    recv_pub_reg[j] <= reg_wdata_i;
                end
            end
            for (int g = 0; g < NUM_GP_WORDS; g++) begin
                if (reg_idx_i == IDX_GP_STORE + 9'(g)) begin
                    gp_store_reg[g] <= reg_wdata_i; // [R12] [R13]
                end
            end
            if (reg_idx_i == IDX_INT_EN) begin
                int_en_reg <= reg_wdata_i[N_RECV-1:0];
            end
        end
    end

    // Interrupt only for enabled flags
    assign irq_o = |(recv_flag_reg & int_en_reg); // [R20]

    // Read data, registered; unmapped reads zero
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= RST_WORD;
        end else if (reg_rd_i) begin
            reg_rdata_o <= RST_WORD;
            for (int i = 0; i < N_SEND; i++) begin
                if (reg_idx_i == IDX_SEND_MASK + 9'(i)) begin
                    reg_rdata_o <= 32'(send_mask_reg[i]);
                end
                if (reg_idx_i == IDX_SEND_SUB + 9'(i)) begin
                    reg_rdata_o <= send_sub_reg[i];
                end
            end
            for (int j = 0; j < N_RECV; j++) begin
                if (reg_idx_i == IDX_RECV_MASK + 9'(j)) begin
                    reg_rdata_o <= 32'(recv_mask_reg[j]);
                end
                if (reg_idx_i == IDX_RECV_PUB + 9'(j)) begin
                    reg_rdata_o <= recv_pub_reg[j];
                end
                if (reg_idx_i == IDX_RECV_FLAG + 9'(j)) begin
                    reg_rdata_o <= {31'h0, recv_flag_reg[j]}; // [R17]
                end
            end
            for (int g = 0; g < NUM_GP_WORDS; g++) begin
                if (reg_idx_i == IDX_GP_STORE + 9'(g)) begin
                    reg_rdata_o <= gp_store_reg[g]; // [R13]
                end
            end
            if (reg_idx_i == IDX_INT_EN) begin
                reg_rdata_o <= 32'(int_en_reg);
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/ipc_sig_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Peer end: pulses chosen channels and reports channel activity
module ipc_sig_peer
    import ipc_sig_pkg::*;
#(
    parameter int N_CH = NUM_CHANNELS,
    parameter int SPACING = MIN_SPACING_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // User send request
    input wire logic send_req_i,
    input wire logic [N_CH-1:0] send_chans_i,
    output logic send_ready_o,
    // Observed channel activity
    output logic [N_CH-1:0] seen_o,
    // Shared channels
    ipc_channel_if.peer_end chan
);
    logic [N_CH-1:0] pulse_reg;
    logic [7:0] gap_reg;

    // Spacing guard keeps same-channel events apart
    assign send_ready_o = (gap_reg == 8'h00); // [R8]

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pulse_reg <= '0;
            gap_reg <= 8'h00;
        end else if (send_req_i && send_ready_o) begin
            pulse_reg <= send_chans_i; // [R6] [R11]
            gap_reg <= 8'(SPACING);
        end else begin
            pulse_reg <= '0;
            gap_reg <= (gap_reg == 8'h00) ? 8'h00 : gap_reg - 8'h01;
        end
    end
    assign chan.peer_pulse = pulse_reg;

    // Registered snapshot of shared channels
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            seen_o <= '0;
        end else begin
            seen_o <= chan.chan_line;
        end
    end
endmodule
`default_nettype wire
